// [rtl/nvm_access_pkg.sv]
// Shared constants and carrier types for the data EEPROM access controller.
package nvm_access_pkg;

  // Array geometry.
  localparam int NVM_DEPTH = 128;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Special function register placement.
  localparam logic [7:0] CTRL_OFFSET = 8'h40;
  localparam logic [1:0] CTRL_BANK = 2'h1;
  localparam logic [7:0] INDEX_OFFSET = 8'h1E;
  localparam logic [7:0] VALUE_OFFSET = 8'h1F;

  // Control register field positions.
  localparam int CTRL_PROGRAM_ENABLE_BIT = 3;
  localparam int CTRL_WRITE_START_BIT = 2;
  localparam int CTRL_FETCH_ENABLE_BIT = 1;
  localparam int CTRL_READ_START_BIT = 0;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] INDEX_RESET = 7'h00;
  localparam logic [DATA_W-1:0] VALUE_RESET = 8'h00;

  // Timing: the read time is a least time, so it rounds up to whole cycles.
  localparam int CLK_PERIOD_NS = 25;
  localparam int READ_TIME_NS = 100;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Write duration in ticks of the slow sub clock, counted by the internal timer.
  localparam int WRITE_SUB_TICKS = 64;

  // One access from the core to the special function register space.
  typedef struct packed {
    logic [1:0] bank;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_s;

endpackage

// [rtl/nvm_array.sv]
// Byte-wide non-volatile data array with one write port and a registered read port.
`timescale 1ns/1ps
module nvm_array #(
  parameter int DEPTH = nvm_access_pkg::NVM_DEPTH,
  parameter int AW = nvm_access_pkg::ADDR_W,
  parameter int DW = nvm_access_pkg::DATA_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);

  if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
    $error("nvm_array: depth does not fit the address width");
  end

  // Contents survive reset on purpose: this models retained storage.
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_q;

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (i_ce) begin
      rdata_q <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_q;

endmodule

// [rtl/nvm_write_timer.sv]
// Write-cycle timer that advances only on ticks of the slow sub clock.
`timescale 1ns/1ps
module nvm_write_timer #(
  parameter int TICKS = nvm_access_pkg::WRITE_SUB_TICKS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_sub_tick,
  output logic o_busy,
  output logic o_done
);

  localparam int CW = (TICKS > 1) ? $clog2(TICKS) : 1;

  if (TICKS < 1) begin : g_bad_ticks
    $error("nvm_write_timer: at least one sub clock tick is needed");
  end

  logic [CW-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  wire last_tick = busy_q && i_sub_tick && (cnt_q == '0);

  // The sub clock is unrelated to the system clock, so the finish moves
  // against instruction timing from one write to the next.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= last_tick;
      if (i_start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= CW'(TICKS - 1);
      end else if (last_tick) begin
        busy_q <= 1'b0;
      end else if (busy_q && i_sub_tick) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule

// [rtl/eeprom_data_access_ctrl.sv]
// Core-side access controller for the byte-wide data EEPROM.
`timescale 1ns/1ps
// Behaviour
// (R1) A 128 by 8 retained array, reached one byte per operation through the registers.
// (R2) Byte index register holds a 7-bit address, resets to zero, bit 7 reads zero.
// (R3) Byte value register is 8-bit read/write, resets to zero, holds write or fetched byte.
// (R4) Software reaches the control register indirectly at 40H with bank select 01H.
// (R5) Control bit 3 is program enable; while low, no array write happens.
// (R6) Bit 2 starts a write only if program enable already set; hardware clears it.
// (R7) Control bit 1 is fetch enable; while low, no array read happens.
// (R8) Bit 0 starts a read only if fetch enable already set; hardware clears it.
// (R9) Control bits 7 to 4 are unimplemented and read zero.
// (R10) Software never sets enables with starts at once, nor both starts together.
// (R11) Software starts a write only once the slow sub clock is stable.
// (R12) Software leaves the access registers alone until a write has finished.
// (R13) Read: load address, set fetch enable, set read start; cleared start means data valid.
// (R14) Value register keeps the fetched byte until the next read or write operation.
// (R15) Write: load address and data, set program enable, then write start next cycle.
// (R16) Software should mask global interrupts around the start of a write.
// (R17) Write duration is set by a timer asynchronous to the system clock.
// (R18) Write end shows as write start clearing and as an interrupt indication.
// (R19) Write end sets the done flag and the multi-function request flag together.
// (R20) Software does not idle or sleep before an operation has completed.
// (R21) A read completes a fixed, parameterised number of system clocks after its start.
module eeprom_data_access_ctrl #(
  parameter int READ_CYCLES = nvm_access_pkg::READ_CYCLES,
  parameter int WRITE_SUB_TICKS = nvm_access_pkg::WRITE_SUB_TICKS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire nvm_access_pkg::sfr_req_s i_sfr,
  input wire logic i_sub_tick,
  input wire logic i_done_clr,
  input wire logic i_mf_clr,
  output logic [7:0] o_sfr_rdata,
  output logic o_nvm_done_flag,
  output logic o_mf_req_flag,
  output logic o_write_busy,
  output logic o_read_busy
);

  localparam int RCW = (READ_CYCLES > 1) ? $clog2(READ_CYCLES) : 1;

  if (READ_CYCLES < 1) begin : g_bad_read
    $error("eeprom_data_access_ctrl: read needs at least one cycle");
  end
  if (WRITE_SUB_TICKS < 1) begin : g_bad_write
    $error("eeprom_data_access_ctrl: write needs at least one sub clock tick");
  end

  // One register hit test serves all three registers.
  function automatic logic reg_hit(input nvm_access_pkg::sfr_req_s req, input logic [7:0] offset,
                                   input logic bank_matters, input logic [1:0] bank);
    reg_hit = (req.addr == offset) && (!bank_matters || (req.bank == bank));
  endfunction

  // Register state.
  logic [nvm_access_pkg::ADDR_W-1:0] index_q;
  logic [nvm_access_pkg::DATA_W-1:0] value_q;
  logic program_enable_q;
  logic write_start_q;
  logic fetch_enable_q;
  logic read_start_q;
  logic [RCW-1:0] read_cnt_q;
  logic done_flag_q;
  logic mf_flag_q;
  logic [7:0] rdata_q;

  // Address decode.
  wire hit_index = reg_hit(i_sfr, nvm_access_pkg::INDEX_OFFSET, 1'b0, 2'h0);
  wire hit_value = reg_hit(i_sfr, nvm_access_pkg::VALUE_OFFSET, 1'b0, 2'h0);
  // The control register sits in bank 1 only, which guards it against stray writes.
  wire hit_ctrl = reg_hit(i_sfr, nvm_access_pkg::CTRL_OFFSET, 1'b1, nvm_access_pkg::CTRL_BANK); // [R4]

  wire wr_index = i_sfr.wr && hit_index;
  wire wr_value = i_sfr.wr && hit_value;
  wire wr_ctrl = i_sfr.wr && hit_ctrl;

  wire any_busy = write_start_q || read_start_q;

  // A start only counts against the enable already held, never one written in
  // the same access, and no start is taken while an operation runs.
  wire write_go = wr_ctrl && i_sfr.wdata[nvm_access_pkg::CTRL_WRITE_START_BIT]
                  && program_enable_q && !any_busy; // [R6] [R10]
  // If both starts arrive together the write is taken and the read dropped.
  wire read_go = wr_ctrl && i_sfr.wdata[nvm_access_pkg::CTRL_READ_START_BIT]
                 && fetch_enable_q && !any_busy && !write_go; // [R8] [R10]

  // Write timing; the timer's own busy is not needed because write start covers the whole cycle.
  logic write_done;

  nvm_write_timer #(
    .TICKS(WRITE_SUB_TICKS)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(write_go),
    .i_sub_tick(i_sub_tick),
    .o_busy(),
    .o_done(write_done)
  ); // [R17]

  // Commit only if program enable is still high when the timer ends.
  wire write_commit = write_done && program_enable_q; // [R5]

  // Read timing.
  wire read_last = read_start_q && (read_cnt_q == '0); // [R21]
  // Clearing fetch enable during a read leaves the value register untouched.
  wire read_capture = read_last && fetch_enable_q; // [R7]

  // The array.
  logic [nvm_access_pkg::DATA_W-1:0] array_rdata;

  nvm_array #(
    .DEPTH(nvm_access_pkg::NVM_DEPTH),
    .AW(nvm_access_pkg::ADDR_W),
    .DW(nvm_access_pkg::DATA_W)
  ) u_array (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_we(write_commit),
    .i_addr(index_q),
    .i_wdata(value_q),
    .o_rdata(array_rdata)
  ); // [R1]

  // Read-back view of each register.
  wire [7:0] index_view = {1'b0, index_q}; // [R2]
  wire [7:0] ctrl_view = {4'h0, program_enable_q, write_start_q, fetch_enable_q, read_start_q}; // [R9]
  wire [7:0] read_mux = hit_index ? index_view :
                        hit_value ? value_q :
                        hit_ctrl ? ctrl_view : 8'h00;

  // Byte index register.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      index_q <= nvm_access_pkg::INDEX_RESET; // [R2]
    end else if (i_ce && wr_index) begin
      index_q <= i_sfr.wdata[nvm_access_pkg::ADDR_W-1:0]; // [R2]
    end
  end

  // Byte value register; a finished read wins over a software write in the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      value_q <= nvm_access_pkg::VALUE_RESET; // [R3]
    end else if (i_ce) begin
      if (read_capture) begin
        value_q <= array_rdata; // [R13]
      end else if (wr_value) begin
        value_q <= i_sfr.wdata; // [R3] [R14]
      end
    end
  end

  // Enable bits follow software writes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      program_enable_q <= nvm_access_pkg::CTRL_RESET[nvm_access_pkg::CTRL_PROGRAM_ENABLE_BIT];
      fetch_enable_q <= nvm_access_pkg::CTRL_RESET[nvm_access_pkg::CTRL_FETCH_ENABLE_BIT];
    end else if (i_ce && wr_ctrl) begin
      program_enable_q <= i_sfr.wdata[nvm_access_pkg::CTRL_PROGRAM_ENABLE_BIT]; // [R5]
      fetch_enable_q <= i_sfr.wdata[nvm_access_pkg::CTRL_FETCH_ENABLE_BIT]; // [R7]
    end
  end

  // Write start: software can only set it, hardware clears it at the end.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      write_start_q <= nvm_access_pkg::CTRL_RESET[nvm_access_pkg::CTRL_WRITE_START_BIT];
    end else if (i_ce) begin
      if (write_go) begin
        write_start_q <= 1'b1; // [R6]
      end else if (write_done) begin
        write_start_q <= 1'b0; // [R6] [R18]
      end
    end
  end

  // Read start and its cycle counter.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      read_start_q <= nvm_access_pkg::CTRL_RESET[nvm_access_pkg::CTRL_READ_START_BIT];
      read_cnt_q <= '0;
    end else if (i_ce) begin
      if (read_go) begin
        read_start_q <= 1'b1; // [R8]
        read_cnt_q <= RCW'(READ_CYCLES - 1); // [R21]
      end else if (read_last) begin
        read_start_q <= 1'b0; // [R8] [R13]
      end else if (read_start_q) begin
        read_cnt_q <= read_cnt_q - 1'b1;
      end
    end
  end

  // Done and multi-function request flags; a new write end beats a clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_flag_q <= 1'b0;
      mf_flag_q <= 1'b0;
    end else if (i_ce) begin
      if (write_done) begin
        done_flag_q <= 1'b1; // [R18] [R19]
      end else if (i_done_clr) begin
        done_flag_q <= 1'b0;
      end
      if (write_done) begin
        mf_flag_q <= 1'b1; // [R19]
      end else if (i_mf_clr) begin
        mf_flag_q <= 1'b0;
      end
    end
  end

  // Read data is registered, so it answers one clock after the read strobe.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (i_ce && i_sfr.rd) begin
      rdata_q <= read_mux;
    end
  end

  assign o_sfr_rdata = rdata_q;
  assign o_nvm_done_flag = done_flag_q;
  assign o_mf_req_flag = mf_flag_q;
  assign o_write_busy = write_start_q;
  assign o_read_busy = read_start_q;

endmodule

// [testbench/eeprom_data_access_ctrl_sva.sv]
// Port-level assertions for the data EEPROM access controller.
`timescale 1ns/1ps
module eeprom_data_access_ctrl_sva #(
  parameter int READ_CYCLES = 4,
  parameter int WRITE_SUB_TICKS = 64
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire nvm_access_pkg::sfr_req_s i_sfr,
  input wire logic i_sub_tick,
  input wire logic i_done_clr,
  input wire logic i_mf_clr,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_nvm_done_flag,
  input wire logic o_mf_req_flag,
  input wire logic o_write_busy,
  input wire logic o_read_busy
);
  logic ctl_sel;
  assign ctl_sel = i_ce && i_sfr.addr == 8'h40 && i_sfr.bank == 2'h1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rd_start; $rose(o_read_busy) |-> $past(ctl_sel && i_sfr.wr && i_sfr.wdata[0]); endproperty
  a_rd_start: assert property (p_rd_start) else $error("read busy rose without a start write");
  property p_wr_start; $rose(o_write_busy) |-> $past(ctl_sel && i_sfr.wr && i_sfr.wdata[2]); endproperty
  a_wr_start: assert property (p_wr_start) else $error("write busy rose without a start write");
  property p_wr_end; $fell(o_write_busy) |-> o_nvm_done_flag && o_mf_req_flag; endproperty
  a_wr_end: assert property (p_wr_end) else $error("write ended without both flags");
  property p_flags; $rose(o_nvm_done_flag) |-> o_mf_req_flag; endproperty
  a_flags: assert property (p_flags) else $error("done flag set alone");
  property p_sticky; o_nvm_done_flag && !i_done_clr |=> o_nvm_done_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("done flag dropped without clear");
  property p_mf_sticky; o_mf_req_flag && !i_mf_clr |=> o_mf_req_flag; endproperty
  a_mf_sticky: assert property (p_mf_sticky) else $error("request flag dropped without clear");
  // The timer ends on the tick edge, its done pulse clears write start one edge later.
  property p_wr_tick; $fell(o_write_busy) |-> $past(i_sub_tick, 2); endproperty
  a_wr_tick: assert property (p_wr_tick) else $error("write ended off a sub clock tick");
  // Exact length for the bench's read time of four cycles.
  property p_rd_len; $rose(o_read_busy) |-> o_read_busy[*4] ##1 !o_read_busy; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read cycle length wrong");
  property p_ctl_hi; ctl_sel && i_sfr.rd |=> o_sfr_rdata[7:4] == 4'h0; endproperty
  a_ctl_hi: assert property (p_ctl_hi) else $error("control top bits not zero");
  property p_hold; !(i_ce && i_sfr.rd) |=> $stable(o_sfr_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
endmodule

// [testbench/core_program_model.sv]
// Core program model: issues register accesses and paces the slow sub clock.
`timescale 1ns/1ps
module core_program_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output nvm_access_pkg::sfr_req_s o_sfr,
  output logic o_sub_tick
);
  int tick_cnt = 0;
  initial o_sfr = '0;
  initial o_sub_tick = 1'b0;
  // Ticks run from the start, so the sub clock is settled before any write.
  always @(posedge i_clk) begin
    tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
    o_sub_tick <= #1 (tick_cnt == 4);
  end
  // Bank and offset pick the control register; strobes last one cycle.
  task automatic access(input logic [1:0] b, input logic [7:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge i_clk);
    #1 o_sfr = '{bank: b, addr: a, wr: w, rd: !w, wdata: d};
    @(posedge i_clk);
    #1 o_sfr.wr = 1'b0;
    o_sfr.rd = 1'b0;
    q = i_rdata;
  endtask
endmodule

// [testbench/eeprom_data_access_ctrl_tb.sv]
// Self-checking bench for the data EEPROM access controller.
`timescale 1ns/1ps
module eeprom_data_access_ctrl_tb;
  localparam logic [7:0] CTL = 8'h40;
  localparam logic [7:0] IDX = 8'h1E;
  localparam logic [7:0] VAL = 8'h1F;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_done_clr = 1'b0;
  logic i_mf_clr = 1'b0;
  nvm_access_pkg::sfr_req_s sfr;
  logic sub_tick;
  logic [7:0] rdata;
  logic done_flag;
  logic mf_flag;
  logic wbusy;
  logic rbusy;
  logic [7:0] q;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int i;
  always #12.5 i_clk = ~i_clk;
  core_program_model core (.i_clk(i_clk), .i_rdata(rdata), .o_sfr(sfr), .o_sub_tick(sub_tick));
  eeprom_data_access_ctrl #(.READ_CYCLES(4), .WRITE_SUB_TICKS(3)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_ce(1'b1), .i_sfr(sfr), .i_sub_tick(sub_tick), .i_done_clr(i_done_clr), .i_mf_clr(i_mf_clr),
    .o_sfr_rdata(rdata), .o_nvm_done_flag(done_flag), .o_mf_req_flag(mf_flag), .o_write_busy(wbusy),
    .o_read_busy(rbusy));
  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.access(2'h1, a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    core.access(2'h1, a, 1'b0, 8'h00, q);
    chk(n, e, q);
  endtask
  task automatic wait_idle;
    for (i = 0; i < 300 && (wbusy !== 1'b0 || rbusy !== 1'b0); i++) begin
      @(posedge i_clk);
      #2;
    end
  endtask
  task automatic do_write(input logic [7:0] a, input logic [7:0] d);
    wr(IDX, a);
    wr(VAL, d);
    // The core model services no interrupt, so nothing can break in between enable and start.
    wr(CTL, 8'h08);
    wr(CTL, 8'h0C);
    chk("write busy", 8'h01, {7'h00, wbusy});
    wait_idle();
  endtask
  task automatic do_read(input logic [7:0] a, input logic [7:0] e);
    wr(IDX, a);
    wr(CTL, 8'h02);
    wr(CTL, 8'h03);
    chk("read busy", 8'h01, {7'h00, rbusy});
    wait_idle();
    rd_chk("control after read", CTL, 8'h02);
    rd_chk("fetched value", VAL, e);
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge i_clk);
    #1 i_rst = 1'b0;
    rd_chk("index reset", IDX, 8'h00);
    rd_chk("value reset", VAL, 8'h00);
    rd_chk("control reset", CTL, 8'h00);
    wr(IDX, 8'hFF);
    rd_chk("index top bit", IDX, 8'h7F);
    wr(CTL, 8'hF0);
    rd_chk("control top bits", CTL, 8'h00);
    core.access(2'h0, CTL, 1'b1, 8'h02, q);
    rd_chk("control in bank zero", CTL, 8'h00);
    wr(CTL, 8'h04);
    rd_chk("write start refused", CTL, 8'h00);
    wr(CTL, 8'h01);
    rd_chk("read start refused", CTL, 8'h00);
    do_write(8'h05, 8'h3C);
    chk("done flag", 8'h01, {7'h00, done_flag});
    chk("mf flag", 8'h01, {7'h00, mf_flag});
    rd_chk("control after write", CTL, 8'h08);
    i_done_clr = 1'b1;
    i_mf_clr = 1'b1;
    @(posedge i_clk);
    #1 i_done_clr = 1'b0;
    i_mf_clr = 1'b0;
    chk("flags cleared", 8'h00, {6'h00, done_flag, mf_flag});
    // Without program enable the start is dropped, so the stored byte must survive.
    wr(CTL, 8'h00);
    wr(VAL, 8'h99);
    wr(CTL, 8'h04);
    repeat (30) @(posedge i_clk);
    #1 chk("no write without enable", 8'h00, {6'h00, wbusy, done_flag});
    do_read(8'h05, 8'h3C);
    do_write(8'h7F, 8'hA5);
    do_write(8'h00, 8'h5A);
    do_read(8'h7F, 8'hA5);
    do_read(8'h00, 8'h5A);
    repeat (10) @(posedge i_clk);
    rd_chk("value held", VAL, 8'h5A);
    tally_and_finish();
  end
endmodule
bind eeprom_data_access_ctrl eeprom_data_access_ctrl_sva #(.READ_CYCLES(READ_CYCLES),
  .WRITE_SUB_TICKS(WRITE_SUB_TICKS)) sva_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sfr(i_sfr),
  .i_sub_tick(i_sub_tick), .i_done_clr(i_done_clr), .i_mf_clr(i_mf_clr), .o_sfr_rdata(o_sfr_rdata),
  .o_nvm_done_flag(o_nvm_done_flag), .o_mf_req_flag(o_mf_req_flag), .o_write_busy(o_write_busy),
  .o_read_busy(o_read_busy));
